// ==== ds1_line_rx_path_perf_monitor.sv ====
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module ds1_line_rx_path_perf_monitor
    import ds1_pm_pkg::*;
#(
    parameter int unsigned P_SEC_CYCLES = SEC_CYCLES
) (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_bipolar_violation,
    input wire logic i_excess_zeros_event,
    input wire logic i_los_defect,
    input wire logic i_crc6_error,
    input wire logic i_frame_bit_error,
    input wire logic i_cof_event,
    input wire logic i_severely_errored_frame_defect,
    input wire logic i_ais_defect,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_irq,
    output logic o_unavail,
    output logic o_second_tick,
    output logic [5:0] o_threshold_crossing_alert
);
    ////////////////////////////////////////////////////////////////////////////
    logic esf_r;
    logic clr_r;
    logic [7:0] stat_r;
    logic [7:0] stat_nxt;
    logic [7:0] mask_r;
    logic [31:0] thr_r [N_THR];
    logic [31:0] cnt [N_CNT];
    logic [31:0] thr_cnt [N_CNT];
    logic [3:0] inc [N_CNT];
    logic [N_CNT-1:0] threshold_crossing_alert;
    logic [31:0] div_r;
    logic tick;
    logic [10:0] sec_anom_r;
    logic [8:0] sec_perr_r;
    logic sec_los_r;
    logic sec_cof_r;
    logic sec_sef_r;
    logic sec_ais_r;
    logic path_err_ev;
    logic line_es;
    logic line_ses;
    logic path_es;
    logic path_ses;
    logic path_sas;
    logic [3:0] ses_run_r;
    logic [3:0] clr_run_r;
    logic [3:0] uas_inc;
    logic unav_r;
    logic unav_nxt;
    logic [5:0] tca_prev_r;

    ////////////////////////////////////////////////////////////////////////////
    // One-second divider
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            div_r <= 32'h0000_0000;
        end else if (div_r >= P_SEC_CYCLES - 1) begin
            div_r <= 32'h0000_0000;
        end else begin
            div_r <= div_r + 32'h0000_0001;
        end
    end

    assign tick = (div_r >= P_SEC_CYCLES - 1);

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_second_tick <= 1'b0;
        end else begin
            o_second_tick <= tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-second anomaly totals and defect flags
    assign path_err_ev = esf_r ? i_crc6_error : i_frame_bit_error;

    // Events in the tick cycle open the next second
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sec_anom_r <= 11'h000;
            sec_perr_r <= 9'h000;
        end else if (tick) begin
            sec_anom_r <= {10'h000, i_bipolar_violation} + {10'h000, i_excess_zeros_event};
            sec_perr_r <= {8'h00, path_err_ev};
        end else begin
            if (sec_anom_r < LINE_SES_LIMIT) begin
                sec_anom_r <= sec_anom_r + {10'h000, i_bipolar_violation} + {10'h000, i_excess_zeros_event};
            end
            if (sec_perr_r < ESF_SES_LIMIT) begin
                sec_perr_r <= sec_perr_r + {8'h00, path_err_ev};
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sec_los_r <= 1'b0;
            sec_cof_r <= 1'b0;
            sec_sef_r <= 1'b0;
            sec_ais_r <= 1'b0;
        end else if (tick) begin
            sec_los_r <= i_los_defect;
            sec_cof_r <= i_cof_event;
            sec_sef_r <= i_severely_errored_frame_defect;
            sec_ais_r <= i_ais_defect;
        end else begin
            sec_los_r <= sec_los_r | i_los_defect;
            sec_cof_r <= sec_cof_r | i_cof_event;
            sec_sef_r <= sec_sef_r | i_severely_errored_frame_defect;
            sec_ais_r <= sec_ais_r | i_ais_defect;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Classification of the finished second
    always_comb begin
        line_es = (sec_anom_r != 11'h000) || sec_los_r;
        line_ses = (sec_anom_r >= LINE_SES_LIMIT) || sec_los_r;
        path_es = (sec_perr_r != 9'h000) || sec_cof_r || sec_sef_r || sec_ais_r;
        path_sas = sec_sef_r || sec_ais_r;
        path_ses = (sec_perr_r >= (esf_r ? ESF_SES_LIMIT : SF_SES_LIMIT)) || path_sas;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Availability. Clean seconds while unavailable stay pending until the
    // run either reaches ten (dropped) or breaks (booked as unavailable).
    always_comb begin
        unav_nxt = unav_r;
        uas_inc = 4'h0;
        if (tick) begin
            if (!unav_r) begin
                if (path_ses && ses_run_r == UNAV_RUN - 4'h1) begin
                    unav_nxt = 1'b1;
                    uas_inc = UNAV_RUN;
                end
            end else if (path_ses) begin
                uas_inc = clr_run_r + 4'h1;
            end else if (clr_run_r == UNAV_RUN - 4'h1) begin
                unav_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ses_run_r <= 4'h0;
            clr_run_r <= 4'h0;
        end else if (tick) begin
            ses_run_r <= (path_ses && !unav_nxt) ? ses_run_r + 4'h1 : 4'h0;
            clr_run_r <= (!path_ses && unav_nxt) ? clr_run_r + 4'h1 : 4'h0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            unav_r <= 1'b0;
        end else begin
            unav_r <= unav_nxt;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_unavail <= 1'b0;
        end else begin
            o_unavail <= unav_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Accumulators
    always_comb begin
        inc[IDX_LCV] = {3'h0, i_bipolar_violation} + {3'h0, i_excess_zeros_event};
        inc[IDX_LES] = {3'h0, tick & line_es};
        inc[IDX_LSES] = {3'h0, tick & line_ses};
        inc[IDX_LOSS] = {3'h0, tick & sec_los_r};
        inc[IDX_PCV] = {3'h0, path_err_ev};
        inc[IDX_PES] = {3'h0, tick & path_es};
        inc[IDX_PSES] = {3'h0, tick & path_ses};
        inc[IDX_PUAS] = uas_inc;
        inc[IDX_PAIS] = {3'h0, tick & sec_ais_r};
        inc[IDX_PSAS] = {3'h0, tick & path_sas};
    end

    // Line counts carry no threshold
    always_comb begin
        for (int i = 0; i < N_CNT; i++) begin
            thr_cnt[i] = 32'h0000_0000;
        end
        for (int i = 0; i < N_THR; i++) begin
            thr_cnt[IDX_PCV + i] = thr_r[i];
        end
    end

    for (genvar g = 0; g < N_CNT; g++) begin : g_cnt
        ds1_pm_counter u_cnt (
            .i_clk_sys(i_clk_sys),
            .i_arst_n(i_arst_n),
            .i_clear(clr_r),
            .i_inc(inc[g]),
            .i_thr(thr_cnt[g]),
            .o_count(cnt[g]),
            .o_tca(threshold_crossing_alert[g])
        );
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_threshold_crossing_alert <= 6'h00;
            tca_prev_r <= 6'h00;
        end else begin
            o_threshold_crossing_alert <= threshold_crossing_alert[N_CNT-1:IDX_PCV];
            tca_prev_r <= threshold_crossing_alert[N_CNT-1:IDX_PCV];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            esf_r <= CTRL_ESF_RST;
            clr_r <= 1'b0;
        end else begin
            clr_r <= i_wr && i_addr == ADDR_CTRL && i_wdata[CTRL_CLR_BIT];
            if (i_wr && i_addr == ADDR_CTRL) begin
                esf_r <= i_wdata[CTRL_ESF_BIT];
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mask_r <= MASK_RST;
        end else if (i_wr && i_addr == ADDR_MASK) begin
            mask_r <= i_wdata[7:0];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (int i = 0; i < N_THR; i++) begin
                thr_r[i] <= THR_RST;
            end
        end else begin
            for (int i = 0; i < N_THR; i++) begin
                if (i_wr && i_addr == ADDR_THR_BASE + 8'(4 * i)) begin
                    thr_r[i] <= i_wdata;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky status; a read clears, a new event in that cycle survives
    always_comb begin
        stat_nxt = (i_rd && i_addr == ADDR_STAT) ? 8'h00 : stat_r;
        stat_nxt[5:0] = stat_nxt[5:0] | (threshold_crossing_alert[N_CNT-1:IDX_PCV] & ~tca_prev_r);
        stat_nxt[STAT_SEC_BIT] = stat_nxt[STAT_SEC_BIT] | tick;
        stat_nxt[STAT_UNAV_BIT] = stat_nxt[STAT_UNAV_BIT] | (unav_nxt ^ unav_r);
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            stat_r <= 8'h00;
            o_irq <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            o_irq <= |(stat_nxt & mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register reads; unmapped addresses read zero
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            o_rdata <= 32'h0000_0000;
            if (i_addr == ADDR_CTRL) begin
                o_rdata <= {31'h0, esf_r};
            end
            if (i_addr == ADDR_STAT) begin
                o_rdata <= {24'h0, stat_r};
            end
            if (i_addr == ADDR_MASK) begin
                o_rdata <= {24'h0, mask_r};
            end
            if (i_addr == ADDR_STATE) begin
                o_rdata <= {25'h0, threshold_crossing_alert[N_CNT-1:IDX_PCV], unav_r};
            end
            for (int i = 0; i < N_THR; i++) begin
                if (i_addr == ADDR_THR_BASE + 8'(4 * i)) begin
                    o_rdata <= thr_r[i];
                end
            end
            for (int i = 0; i < N_CNT; i++) begin
                if (i_addr == ADDR_CNT_BASE + 8'(4 * i)) begin
                    o_rdata <= cnt[i];
                end
            end
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    AST_LCV: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (!clr_r && cnt[IDX_LCV] < 32'hFFFF_0000) |=>
        cnt[IDX_LCV] == $past(cnt[IDX_LCV]) + 32'($past(inc[IDX_LCV])))
        else $error("Line violation count wrong");
    AST_LES: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (tick && !clr_r && sec_anom_r != 11'h000) |=> cnt[IDX_LES] == $past(cnt[IDX_LES]) + 32'h1)
        else $error("Line errored second missed");
    AST_LSES: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (tick && !clr_r) |=> cnt[IDX_LSES] == $past(cnt[IDX_LSES])
            + (($past(sec_anom_r) >= LINE_SES_LIMIT || $past(sec_los_r)) ? 32'h1 : 32'h0))
        else $error("Line severe second wrong");
    AST_LOSS: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (tick && !clr_r && sec_los_r) |=> cnt[IDX_LOSS] == $past(cnt[IDX_LOSS]) + 32'h1)
        else $error("Loss second missed");
    AST_AISS: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (!tick && !clr_r) |=> $stable(cnt[IDX_PAIS]))
        else $error("Alarm second counted off tick");
    AST_PCV: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (!clr_r && !esf_r && i_frame_bit_error && !i_crc6_error) |=> cnt[IDX_PCV] == $past(cnt[IDX_PCV]) + 32'h1)
        else $error("Path violation miscounted");
    AST_PES: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (tick && !clr_r && (sec_cof_r || sec_perr_r != 9'h000)) |=> cnt[IDX_PES] == $past(cnt[IDX_PES]) + 32'h1)
        else $error("Path errored second missed");
    AST_SAS: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (tick && !clr_r && sec_sef_r) |=> cnt[IDX_PSAS] == $past(cnt[IDX_PSAS]) + 32'h1)
        else $error("Frame alarm second missed");
    AST_PSES_SF: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (tick && !clr_r && !esf_r && sec_perr_r == 9'h004) |=> cnt[IDX_PSES] == $past(cnt[IDX_PSES]) + 32'h1)
        else $error("Frame bit severe second missed");
    AST_PSES_ESF: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (tick && !clr_r && esf_r && sec_perr_r == 9'h13F && !path_sas) |=> $stable(cnt[IDX_PSES]))
        else $error("Severe second below CRC limit");
    AST_UNAV_ON: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        $rose(unav_r) |-> $past(ses_run_r) == UNAV_RUN - 4'h1 && $past(path_ses))
        else $error("Unavailable entered early");
    AST_UAS_ON: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        ($rose(unav_r) && !$past(clr_r)) |-> cnt[IDX_PUAS] == $past(cnt[IDX_PUAS]) + 32'(UNAV_RUN))
        else $error("Unavailable onset not booked");
    AST_TICK: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        tick |=> sec_cof_r == $past(i_cof_event))
        else $error("Second flags not restarted");
    AST_STAT_SET: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        tick |=> stat_r[STAT_SEC_BIT])
        else $error("Tick status lost");

    COV_UNAV: cover property (@(posedge i_clk_sys) disable iff (!i_arst_n) $rose(unav_r));
    COV_AVAIL: cover property (@(posedge i_clk_sys) disable iff (!i_arst_n) $fell(unav_r));
    COV_TCA: cover property (@(posedge i_clk_sys) disable iff (!i_arst_n) |threshold_crossing_alert);
    COV_IRQ: cover property (@(posedge i_clk_sys) disable iff (!i_arst_n) o_irq);
endmodule
`default_nettype wire

// ==== ds1_pm_pkg.sv ====
package ds1_pm_pkg;
    localparam int unsigned CLK_FREQ_HZ = 50_000_000;
    localparam int unsigned SECOND_S = 1;
    localparam int unsigned SEC_CYCLES = CLK_FREQ_HZ * SECOND_S;

    localparam logic [10:0] LINE_SES_LIMIT = 11'h608;
    localparam logic [8:0] ESF_SES_LIMIT = 9'h140;
    localparam logic [8:0] SF_SES_LIMIT = 9'h004;
    localparam logic [3:0] UNAV_RUN = 4'hA;

    // Counter indices
    localparam int N_CNT = 10;
    localparam int IDX_LCV = 0;
    localparam int IDX_LES = 1;
    localparam int IDX_LSES = 2;
    localparam int IDX_LOSS = 3;
    localparam int IDX_PCV = 4;
    localparam int IDX_PES = 5;
    localparam int IDX_PSES = 6;
    localparam int IDX_PUAS = 7;
    localparam int IDX_PAIS = 8;
    localparam int IDX_PSAS = 9;
    localparam int N_THR = 6;

    // Byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_MASK = 8'h08;
    localparam logic [7:0] ADDR_STATE = 8'h0C;
    localparam logic [7:0] ADDR_THR_BASE = 8'h10;
    localparam logic [7:0] ADDR_CNT_BASE = 8'h40;

    // Control fields
    localparam int CTRL_ESF_BIT = 0;
    localparam int CTRL_CLR_BIT = 1;
    localparam logic CTRL_ESF_RST = 1'b0;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [31:0] THR_RST = 32'h0000_0000;

    // Status fields: bits 5..0 alerts per path threshold
    localparam int STAT_SEC_BIT = 6;
    localparam int STAT_UNAV_BIT = 7;

    function automatic logic [31:0] sat_add(input logic [31:0] a, input logic [3:0] b);
        logic [32:0] s;
        s = {1'b0, a} + {29'h0, b};
        sat_add = s[32] ? 32'hFFFF_FFFF : s[31:0];
    endfunction
endpackage

// ==== ds1_pm_counter.sv ====
`timescale 1ns/10ps
`default_nettype none
module ds1_pm_counter
    import ds1_pm_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_clear,
    input wire logic [3:0] i_inc,
    input wire logic [31:0] i_thr,
    output logic [31:0] o_count,
    output logic o_tca
);
    logic [31:0] count_nxt;

    // Counting carries on past the threshold
    always_comb begin
        count_nxt = i_clear ? 32'h0000_0000 : sat_add(o_count, i_inc);
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_count <= 32'h0000_0000;
        end else begin
            o_count <= count_nxt;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_tca <= 1'b0;
        end else begin
            o_tca <= (i_thr != 32'h0000_0000) && (count_nxt >= i_thr);
        end
    end

    AST_TCA_ZERO: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        $past(i_thr) == 32'h0000_0000 |-> !o_tca)
        else $error("Alert raised with threshold zero");
    AST_TCA_REACH: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_thr != 32'h0000_0000 && o_count >= i_thr && !i_clear && $stable(i_thr)) |=> o_tca)
        else $error("Alert missing at threshold");
endmodule
`default_nettype wire

// ==== ds1_pm_line_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module ds1_pm_line_model (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_start,
    input wire logic [7:0] i_kinds,
    input wire logic [11:0] i_count,
    output logic o_busy,
    output logic [7:0] o_ind
);
    logic [11:0] left_r;
    logic [7:0] kinds_r;

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            left_r <= 12'h000;
            kinds_r <= 8'h00;
        end else if (i_start) begin
            left_r <= i_count;
            kinds_r <= i_kinds;
        end else if (left_r != 12'h000) begin
            left_r <= left_r - 12'h001;
        end
    end

    // Lines go quiet between bursts, so no stale anomaly leaks into the next second
    assign o_ind = (left_r != 12'h000) ? kinds_r : 8'h00;
    assign o_busy = i_start | (left_r != 12'h000);
endmodule
`default_nettype wire

// ==== ds1_line_rx_path_perf_monitor_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module ds1_line_rx_path_perf_monitor_tb_top;
    import ds1_pm_pkg::*;
    // Long enough for 1544 anomalies at two per cycle
    localparam int unsigned SEC = 800;
    localparam logic [7:0] K_BPV = 8'h01, K_EXZ = 8'h02, K_LOS = 8'h04, K_CRC = 8'h08;
    localparam logic [7:0] K_FE = 8'h10, K_COF = 8'h20, K_SEF = 8'h40, K_AIS = 8'h80;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic start = 1'b0;
    logic [7:0] kinds = 8'h00;
    logic [11:0] count = 12'h000;
    logic busy;
    logic [7:0] ind;
    logic [31:0] rdata;
    logic irq;
    logic unavail;
    logic tick;
    logic [5:0] alert;
    int num_errors = 0;
    int num_checks = 0;

    initial forever #10 clk_sys = ~clk_sys;

    ds1_pm_line_model line (.i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_start(start), .i_kinds(kinds),
        .i_count(count), .o_busy(busy), .o_ind(ind));

    ds1_line_rx_path_perf_monitor #(.P_SEC_CYCLES(SEC)) dut (.i_clk_sys(clk_sys), .i_arst_n(arst_n),
        .i_bipolar_violation(ind[0]), .i_excess_zeros_event(ind[1]), .i_los_defect(ind[2]),
        .i_crc6_error(ind[3]), .i_frame_bit_error(ind[4]), .i_cof_event(ind[5]),
        .i_severely_errored_frame_defect(ind[6]), .i_ais_defect(ind[7]), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr_stb), .i_rd(rd_stb), .o_rdata(rdata), .o_irq(irq),
        .o_unavail(unavail), .o_second_tick(tick), .o_threshold_crossing_alert(alert));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wr_stb <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic cnt(input int idx, input logic [31:0] exp);
        rchk(ADDR_CNT_BASE + 8'(4 * idx), exp);
    endtask

    task automatic sec_sync;
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (tick !== 1'b1 && n < SEC + 8);
        if (tick !== 1'b1) begin
            num_errors++;
            $display("FAIL %0t second tick missing", $time);
            results;
        end
    endtask

    task automatic inject(input logic [7:0] k, input logic [11:0] n);
        int w;
        @(posedge clk_sys);
        start <= 1'b1;
        kinds <= k;
        count <= n;
        @(posedge clk_sys);
        start <= 1'b0;
        for (w = 0; w < 4096 && busy === 1'b1; w++) begin
            @(posedge clk_sys);
            #1;
        end
        if (busy !== 1'b0) begin
            num_errors++;
            $display("FAIL %0t burst stuck", $time);
            results;
        end
    endtask

    task automatic one_sec(input logic [7:0] k, input logic [11:0] n);
        sec_sync;
        inject(k, n);
    endtask

    task automatic settle;
        sec_sync;
        repeat (3) @(posedge clk_sys);
    endtask

    // Clear just after a tick so no half-counted second survives it
    task automatic clr(input logic esf);
        settle;
        wr(ADDR_CTRL, {30'h0, 1'b1, esf});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        int i;
        chk({31'h0, unavail}, 32'h0);
        rchk(ADDR_CTRL, 32'h0);
        rchk(ADDR_MASK, 32'h0);
        for (i = 0; i < N_THR; i++) rchk(ADDR_THR_BASE + 8'(4 * i), THR_RST);
        for (i = 0; i < N_CNT; i++) cnt(i, 32'h0);
        wr(8'hFC, 32'hFFFF_FFFF);
        rchk(8'hFC, 32'h0);
        $display("test regs done");
    endtask

    task automatic t_line;
        clr(1'b0);
        one_sec(K_BPV | K_EXZ, 12'd3);
        one_sec(K_LOS, 12'd1);
        one_sec(K_BPV | K_EXZ, 12'd771);
        inject(K_BPV, 12'd1);
        one_sec(K_BPV | K_EXZ, 12'd772);
        settle;
        cnt(IDX_LCV, 32'd3093);
        cnt(IDX_LES, 32'd4);
        cnt(IDX_LSES, 32'd2);
        cnt(IDX_LOSS, 32'd1);
        $display("test line done");
    endtask

    task automatic t_sf;
        clr(1'b0);
        one_sec(K_FE | K_CRC, 12'd3);
        one_sec(K_FE, 12'd4);
        one_sec(K_COF, 12'd1);
        settle;
        cnt(IDX_PCV, 32'd7);
        cnt(IDX_PES, 32'd3);
        cnt(IDX_PSES, 32'd1);
        $display("test superframe done");
    endtask

    task automatic t_esf;
        clr(1'b1);
        rchk(ADDR_CTRL, 32'h0000_0001);
        one_sec(K_CRC | K_FE, 12'd319);
        one_sec(K_CRC, 12'd320);
        one_sec(K_AIS, 12'd1);
        one_sec(K_SEF, 12'd1);
        one_sec(K_COF, 12'd1);
        settle;
        cnt(IDX_PCV, 32'd639);
        cnt(IDX_PES, 32'd5);
        cnt(IDX_PSES, 32'd3);
        cnt(IDX_PAIS, 32'd1);
        cnt(IDX_PSAS, 32'd2);
        $display("test extended superframe done");
    endtask

    task automatic t_unav;
        clr(1'b0);
        wr(ADDR_MASK, 32'h0000_0080);
        repeat (9) one_sec(K_SEF, 12'd1);
        settle;
        chk({31'h0, unavail}, 32'h0);
        // Tenth severe second must follow the ninth with no clean gap
        inject(K_SEF, 12'd1);
        settle;
        chk({31'h0, unavail}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        rchk(ADDR_STATE, 32'h0000_0001);
        cnt(IDX_PUAS, 32'd10);
        rchk(ADDR_STAT, 32'h0000_00C0);
        chk({31'h0, irq}, 32'h0);
        repeat (9) sec_sync;
        repeat (3) @(posedge clk_sys);
        #1;
        chk({31'h0, unavail}, 32'h1);
        settle;
        chk({31'h0, unavail}, 32'h0);
        chk({31'h0, irq}, 32'h1);
        rchk(ADDR_STAT, 32'h0000_00C0);
        cnt(IDX_PUAS, 32'd10);
        cnt(IDX_PSES, 32'd10);
        cnt(IDX_PSAS, 32'd10);
        $display("test unavailable done");
    endtask

    task automatic t_tca;
        clr(1'b0);
        wr(ADDR_THR_BASE, 32'd3);
        wr(ADDR_THR_BASE + 8'h04, 32'd0);
        wr(ADDR_MASK, 32'h0000_0001);
        rchk(ADDR_THR_BASE, 32'd3);
        one_sec(K_FE, 12'd2);
        settle;
        chk({26'h0, alert}, 32'h0);
        inject(K_FE, 12'd1);
        repeat (3) @(posedge clk_sys);
        #1;
        chk({31'h0, alert[0]}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        rchk(ADDR_STATE, 32'h0000_0002);
        one_sec(K_FE, 12'd1);
        settle;
        cnt(IDX_PCV, 32'd4);
        chk({31'h0, alert[1]}, 32'h0);
        rchk(ADDR_STAT, 32'h0000_0041);
        chk({31'h0, irq}, 32'h0);
        $display("test alert done");
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_regs;
        t_line;
        t_sf;
        t_esf;
        t_unav;
        t_tca;
        results;
    end
endmodule
`default_nettype wire
